// File: afs_pkg.sv
// Constants, register map and operation classes of the ALU status flag unit
package afs_pkg;
  // Register bus geometry
  localparam int AFS_ADDR_W = 8;
  localparam int AFS_DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] AFS_OFS_ARITH_STATUS_REG = 8'h00; // Arithmetic status
  localparam logic [7:0] AFS_OFS_STICKY_STATUS_REG = 8'h04; // Sticky exceptions
  localparam logic [7:0] AFS_OFS_IRQ_STAT = 8'h08; // Interrupt status, read only
  localparam logic [7:0] AFS_OFS_IRQ_CLR = 8'h0C; // Interrupt clear, write only
  localparam logic [7:0] AFS_OFS_IRQ_EN = 8'h10; // Interrupt enable
  // Arithmetic status field positions
  localparam int AFS_B_ZERO = 0;
  localparam int AFS_B_OVF = 1;
  localparam int AFS_B_NEG = 2;
  localparam int AFS_B_CARRY = 3;
  localparam int AFS_B_SIGN = 4;
  localparam int AFS_B_INV = 5;
  localparam int AFS_B_FLOAT = 10;
  localparam int AFS_B_HIST = 24;
  localparam int AFS_HIST_W = 8;
  // Sticky status field positions
  localparam int AFS_S_UNDER = 0;
  localparam int AFS_S_FPOVF = 1;
  localparam int AFS_S_FXOVF = 2;
  localparam int AFS_S_INV = 5;
  // Internal sticky vector: one bit per exception, also the interrupt layout
  localparam int AFS_NSTK = 4;
  localparam int AFS_I_UNDER = 0;
  localparam int AFS_I_FPOVF = 1;
  localparam int AFS_I_FXOVF = 2;
  localparam int AFS_I_INV = 3;
  // Reset values
  localparam logic [5:0] AFS_RST_FLAGS = 6'h00;
  localparam logic [7:0] AFS_RST_HIST = 8'h00;
  localparam logic [3:0] AFS_RST_STK = 4'h0;
  // Largest unbiased exponent that still fits
  localparam logic signed [9:0] AFS_EXP_MAX = 10'sd127;
  // Saturation values for fixed-point overflow
  localparam logic [31:0] AFS_SAT_POS = 32'h7FFFFFFF;
  localparam logic [31:0] AFS_SAT_NEG = 32'h80000000;
  // Operation classes as far as flag generation cares
  typedef enum logic [2:0] {
    AFS_OP_ARITH,     // Add, subtract, carry forms, negate, scale, float
    AFS_OP_AVERAGE,   // Halving add: never overflows
    AFS_OP_LOGIC,     // Logic, pass, min, max, clip, copysign
    AFS_OP_MAGNITUDE, // Absolute value
    AFS_OP_SIGEXT,    // Significand extract
    AFS_OP_COMPARE,   // Compare: flags only, no result
    AFS_OP_TO_FIXED   // Float to fixed conversion
  } afs_op_e;
endpackage

// File: afs_sticky.sv
// Bank of sticky bits with software load or clear and hardware set
`timescale 1ns/1ps
module afs_sticky
  import afs_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter bit SET_WINS = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] set_bits,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_bits,
  input wire logic [WIDTH-1:0] clr_bits,
  output logic [WIDTH-1:0] q
);
  // One flop per bit; hardware can only raise a bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        q[i] <= 1'b0;
      end else if (load && !SET_WINS) begin
        // A direct load supersedes the event of the same cycle
        q[i] <= load_bits[i];
      end else if (set_bits[i]) begin
        // Event beats a clear so that none is lost
        q[i] <= 1'b1;
      end else if (clr_bits[i]) begin
        q[i] <= 1'b0;
      end
    end
  end
endmodule

// File: afs_history.sv
// Compare history shift register, loadable by software
`timescale 1ns/1ps
module afs_history
  import afs_pkg::*;
#(
  parameter int DEPTH = AFS_HIST_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [DEPTH-1:0] load_bits,
  input wire logic shift,
  input wire logic new_bit,
  output logic [DEPTH-1:0] history
);
  // Load wins; a shift drops bit 0 and enters the newest result at the top
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      history <= AFS_RST_HIST;
    end else if (load) begin
      history <= load_bits;
    end else if (shift) begin
      history <= {new_bit, history[DEPTH-1:1]};
    end
  end
endmodule

// File: afs_flag_unit.sv
// ALU status and sticky flag generation with register port and interrupt
//
// How it works
// - Flags registered at operation end, readable next
// - Software status writes beat same-cycle flag updates
// - Zero flag: result zero or float underflow
// - Float result tiny sets sticky underflow, zero
// - Negative flag follows result sign
// - Fixed overflow: two top bits differ
// - Float overflow: unbiased exponent above 127
// - Carry from fixed arithmetic and halving add; cleared otherwise
// - Carry forms consume the current carry flag
// - Sign flag only for magnitude and extract
// - Invalid on NaN, bad infinities, conversion; conversion only with saturation off
// - Float op flag shows last operation type
// - Compare history shifts down, newest at top
// - Operations only raise sticky flags
// - Sticky flags hold until software clears
// - Status bits 0-5 and 10 layout
// - Overflow is pre-saturation; saturation optional
// - Sticky bits 0, 1, 2 and 5 layout
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module afs_flag_unit
  import afs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AFS_ADDR_W-1:0] reg_addr,
  input wire logic [AFS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [AFS_DATA_W-1:0] reg_rdata,
  input wire logic op_valid,
  input wire logic op_float,
  input wire afs_op_e op_kind,
  input wire logic op_subtract,
  input wire logic saturate_enable,
  input wire logic [32:0] fix_result_ext,
  input wire logic fix_carry_out,
  input wire logic fp_result_zero,
  input wire logic fp_result_negative,
  input wire logic fp_tiny,
  input wire logic signed [9:0] fp_exponent,
  input wire logic x_negative,
  input wire logic y_negative,
  input wire logic x_nan,
  input wire logic y_nan,
  input wire logic x_inf,
  input wire logic y_inf,
  input wire logic fix_conv_overflow,
  input wire logic cmp_x_gt_y,
  output logic carry_in,
  output logic [31:0] result_out,
  output logic [31:0] arith_status_reg,
  output logic [31:0] sticky_status_reg,
  output logic irq
);
  // Current flags, bit order as in the status register
  logic zero_flag;
  logic overflow_flag;
  logic negative_flag;
  logic carry_flag;
  logic sign_flag;
  logic invalid_flag;
  logic float_op_flag;
  logic [AFS_HIST_W-1:0] compare_history;
  // Next values computed from this cycle's operation
  logic next_zero;
  logic next_overflow;
  logic next_negative;
  logic next_carry;
  logic next_sign;
  logic next_invalid;
  logic [31:0] next_result;
  logic [AFS_NSTK-1:0] next_sticky_set;
  // Sticky exception bits and interrupt bookkeeping
  logic [AFS_NSTK-1:0] sticky_q;
  logic [AFS_NSTK-1:0] irq_status;
  logic [AFS_NSTK-1:0] irq_enable;
  logic [AFS_NSTK-1:0] irq_events;
  // Decoded register writes
  logic arith_status_reg_wr;
  logic sticky_status_reg_wr;
  logic irq_clr_wr;
  logic irq_en_wr;
  logic fix_ovf;
  logic fp_ovf;
  logic tiny_hit;
  logic inf_clash;
  logic [AFS_NSTK-1:0] sticky_status_reg_load;

  assign arith_status_reg_wr = reg_wr && (reg_addr == AFS_OFS_ARITH_STATUS_REG);
  assign sticky_status_reg_wr = reg_wr && (reg_addr == AFS_OFS_STICKY_STATUS_REG);
  assign irq_clr_wr = reg_wr && (reg_addr == AFS_OFS_IRQ_CLR);
  assign irq_en_wr = reg_wr && (reg_addr == AFS_OFS_IRQ_EN);

  // Carry forms see the flag as left by the previous operation
  assign carry_in = carry_flag;

  // Raw overflow terms, qualified by operation class below; judged on the unsaturated result
  assign fix_ovf = fix_result_ext[32] ^ fix_result_ext[31];
  assign fp_ovf = (fp_exponent > AFS_EXP_MAX);
  // Underflow only for ops that yield a float or convert to fixed
  assign tiny_hit = op_float && fp_tiny && (op_kind != AFS_OP_COMPARE);
  // Infinities that cancel: opposite signs added, like signs subtracted
  assign inf_clash = x_inf && y_inf && (op_subtract ? (x_negative == y_negative)
                                                    : (x_negative != y_negative));

  // Flag evaluation for the operation in flight
  always_comb begin
    next_result = fix_result_ext[31:0];
    next_overflow = 1'b0;
    next_carry = 1'b0;
    next_invalid = 1'b0;
    next_sticky_set = '0;
    if (!op_float) begin
      // Saturate only when enabled; otherwise the low word passes unaltered
      if (fix_ovf && saturate_enable) begin
        next_result = fix_result_ext[32] ? AFS_SAT_NEG : AFS_SAT_POS;
      end
      if (op_kind == AFS_OP_ARITH || op_kind == AFS_OP_MAGNITUDE) begin
        next_overflow = fix_ovf;
        next_sticky_set[AFS_I_FXOVF] = fix_ovf;
      end
      if (op_kind == AFS_OP_ARITH || op_kind == AFS_OP_AVERAGE) begin
        next_carry = fix_carry_out;
      end
      next_zero = (next_result == 32'h00000000);
      next_negative = next_result[31];
    end else begin
      // Halving, logic-like and compare forms cannot overflow
      if (op_kind != AFS_OP_AVERAGE && op_kind != AFS_OP_LOGIC &&
          op_kind != AFS_OP_COMPARE) begin
        next_overflow = fp_ovf;
        next_sticky_set[AFS_I_FPOVF] = fp_ovf;
      end
      next_invalid = x_nan || y_nan || ((op_kind == AFS_OP_ARITH) && inf_clash) ||
                     ((op_kind == AFS_OP_TO_FIXED) && !saturate_enable &&
                      (fix_conv_overflow || x_inf));
      next_sticky_set[AFS_I_INV] = next_invalid;
      next_sticky_set[AFS_I_UNDER] = tiny_hit;
      next_zero = fp_result_zero || tiny_hit;
      next_negative = fp_result_negative;
    end
    // Sign of X is reported for magnitude and extract only
    next_sign = ((op_kind == AFS_OP_MAGNITUDE) ||
                 (op_kind == AFS_OP_SIGEXT)) && x_negative;
  end

  // Per-operation flags; a software write that cycle supersedes them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {invalid_flag, sign_flag, carry_flag, negative_flag, overflow_flag,
       zero_flag} <= AFS_RST_FLAGS;
      float_op_flag <= 1'b0;
    end else if (arith_status_reg_wr) begin
      // Explicit write wins over the operation of the same cycle
      {invalid_flag, sign_flag, carry_flag, negative_flag, overflow_flag,
       zero_flag} <= reg_wdata[AFS_B_INV:AFS_B_ZERO];
      float_op_flag <= reg_wdata[AFS_B_FLOAT];
    end else if (op_valid) begin
      // Registered at the end of the operation cycle
      zero_flag <= next_zero;
      overflow_flag <= next_overflow;
      negative_flag <= next_negative;
      carry_flag <= next_carry;
      sign_flag <= next_sign;
      invalid_flag <= next_invalid;
      float_op_flag <= op_float;
    end
  end

  // Returned data come from a flop, like the flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_out <= 32'h00000000;
    end else if (op_valid) begin
      result_out <= next_result;
    end
  end

  // Compare history: shifts on every compare unless software loads it
  afs_history #(
    .DEPTH(AFS_HIST_W)
  ) u_history (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(arith_status_reg_wr),
    .load_bits(reg_wdata[AFS_B_HIST +: AFS_HIST_W]),
    .shift(op_valid && (op_kind == AFS_OP_COMPARE)),
    .new_bit(cmp_x_gt_y),
    .history(compare_history)
  );

  // Sticky exceptions: operations raise, software write reloads
  assign sticky_status_reg_load = {reg_wdata[AFS_S_INV], reg_wdata[AFS_S_FXOVF],
                      reg_wdata[AFS_S_FPOVF], reg_wdata[AFS_S_UNDER]};
  afs_sticky #(
    .WIDTH(AFS_NSTK),
    .SET_WINS(1'b0)
  ) u_sticky (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_bits(op_valid ? next_sticky_set : '0),
    .load(sticky_status_reg_wr),
    .load_bits(sticky_status_reg_load),
    .clr_bits('0),
    .q(sticky_q)
  );

  // Interrupt status: a sticky bit newly rising is an event
  assign irq_events = (op_valid && !sticky_status_reg_wr) ? (next_sticky_set & ~sticky_q) : '0;
  afs_sticky #(
    .WIDTH(AFS_NSTK),
    .SET_WINS(1'b1)
  ) u_irq_status (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_bits(irq_events),
    .load(1'b0),
    .load_bits('0),
    .clr_bits(irq_clr_wr ? reg_wdata[AFS_NSTK-1:0] : '0),
    .q(irq_status)
  );

  // Interrupt enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable <= AFS_RST_STK;
    end else if (irq_en_wr) begin
      irq_enable <= reg_wdata[AFS_NSTK-1:0];
    end
  end

  // Level interrupt while any enabled status bit is set
  assign irq = |(irq_status & irq_enable);

  // Register images, reserved bits read as zero
  always_comb begin
    arith_status_reg = 32'h00000000;
    arith_status_reg[AFS_B_INV:AFS_B_ZERO] = {invalid_flag, sign_flag, carry_flag,
                                              negative_flag, overflow_flag,
                                              zero_flag};
    arith_status_reg[AFS_B_FLOAT] = float_op_flag;
    arith_status_reg[AFS_B_HIST +: AFS_HIST_W] = compare_history;
    sticky_status_reg = 32'h00000000;
    sticky_status_reg[AFS_S_UNDER] = sticky_q[AFS_I_UNDER];
    sticky_status_reg[AFS_S_FPOVF] = sticky_q[AFS_I_FPOVF];
    sticky_status_reg[AFS_S_FXOVF] = sticky_q[AFS_I_FXOVF];
    sticky_status_reg[AFS_S_INV] = sticky_q[AFS_I_INV];
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      unique case (reg_addr)
        AFS_OFS_ARITH_STATUS_REG: reg_rdata <= arith_status_reg;
        AFS_OFS_STICKY_STATUS_REG: reg_rdata <= sticky_status_reg;
        AFS_OFS_IRQ_STAT: reg_rdata <= {28'h0000000, irq_status};
        AFS_OFS_IRQ_EN: reg_rdata <= {28'h0000000, irq_enable};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // Checks on the flag behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_WRITE_WINS: assert property (arith_status_reg_wr |=>
    arith_status_reg[AFS_B_INV:AFS_B_ZERO] == $past(reg_wdata[AFS_B_INV:AFS_B_ZERO]))
    else $error("status write lost to operation");
  AST_FIX_ZERO: assert property (op_valid && !arith_status_reg_wr && !op_float &&
    !saturate_enable && fix_result_ext[31:0] == 32'h00000000 |=> zero_flag)
    else $error("zero flag missed on zero result");
  AST_FIX_OVF: assert property (op_valid && !arith_status_reg_wr && !sticky_status_reg_wr && !op_float &&
    op_kind == AFS_OP_ARITH && (fix_result_ext[32] != fix_result_ext[31])
    |=> overflow_flag && sticky_status_reg[AFS_S_FXOVF])
    else $error("fixed overflow not flagged");
  AST_FP_OVF: assert property (op_valid && !arith_status_reg_wr && op_float &&
    op_kind == AFS_OP_ARITH |=> overflow_flag == ($past(fp_exponent) > AFS_EXP_MAX))
    else $error("float overflow flag wrong");
  AST_CARRY_CLR: assert property (op_valid && !arith_status_reg_wr && (op_float ||
    (op_kind != AFS_OP_ARITH && op_kind != AFS_OP_AVERAGE)) |=> !carry_flag && !carry_in)
    else $error("carry not cleared by non-arithmetic op");
  AST_SIGN_CLR: assert property (op_valid && !arith_status_reg_wr && op_kind != AFS_OP_MAGNITUDE &&
    op_kind != AFS_OP_SIGEXT |=> !sign_flag)
    else $error("sign flag left set");
  AST_FLOAT_FLAG: assert property (op_valid && !arith_status_reg_wr |=>
    float_op_flag == $past(op_float))
    else $error("float op flag wrong");
  AST_HISTORY: assert property (op_valid && !arith_status_reg_wr && op_kind == AFS_OP_COMPARE |=>
    compare_history == {$past(cmp_x_gt_y), $past(compare_history[AFS_HIST_W-1:1])})
    else $error("compare history shift wrong");
  AST_STICKY_HOLD: assert property (sticky_status_reg[AFS_S_INV] && !sticky_status_reg_wr
    |=> sticky_status_reg[AFS_S_INV])
    else $error("sticky invalid dropped without write");
  AST_NO_SAT: assert property (op_valid && !op_float && !saturate_enable
    |=> result_out == $past(fix_result_ext[31:0]))
    else $error("unsaturated result altered");

  // Compares arrive every other cycle from the register file side
  COV_COMPARE_RUN: cover property ((op_valid && op_kind == AFS_OP_COMPARE) ##2
    (op_valid && op_kind == AFS_OP_COMPARE) ##2 (op_valid && op_kind == AFS_OP_COMPARE));
  COV_FP_INVALID: cover property (op_valid && op_float && x_nan ##1 irq);
  COV_WRITE_CLASH: cover property (op_valid && arith_status_reg_wr);
endmodule

// File: afs_regfile_model.sv
// Stand-in for the register file and fixed-point adder that feed the flag unit
`timescale 1ns/1ps
module afs_regfile_model (
  input wire logic [31:0] x_operand,
  input wire logic [31:0] y_operand,
  input wire logic use_carry,
  input wire logic carry_in,
  output logic [32:0] fix_result_ext,
  output logic fix_carry_out
);
  // Carry forms read the flag unit's current carry flag, never a stale copy
  logic cin; // Carry actually consumed
  logic [32:0] unsigned_sum; // Zero-extended sum exposes carry out of bit 31
  assign cin = use_carry & carry_in;
  assign unsigned_sum = {1'b0, x_operand} + {1'b0, y_operand} + {32'h0, cin};
  // Sign-extended sum keeps the extra top bit so overflow stays visible
  assign fix_result_ext = {x_operand[31], x_operand} + {y_operand[31], y_operand}
    + {32'h0, cin};
  assign fix_carry_out = unsigned_sum[32];
endmodule

// File: tb.sv
// Self-checking testbench for the ALU status flag unit
`timescale 1ns/1ps
module tb;
  import afs_pkg::*;
  logic sys_clk = 1'b0; // Core clock
  logic rst_n = 1'b0; // Reset, active low
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic op_valid = 1'b0;
  logic op_float = 1'b0;
  afs_op_e op_kind = AFS_OP_ARITH;
  // Side bits: 13 sat, 12 carry form, 11 y neg, 10 y nan, 9 tiny, 8 fp zero,
  // 7 fp neg, 6 x neg, 5 x nan, 4 x inf, 3 y inf, 2 subtract, 1 conv ovf, 0 x>y
  logic [13:0] misc = 14'h0;
  logic [31:0] opx = 32'h0; // Operand X into the partner adder
  logic [31:0] opy = 32'h0; // Operand Y into the partner adder
  logic [9:0] fp_exp = 10'h000; // Unbiased exponent
  logic [31:0] reg_rdata, result_out, arith_status_reg, sticky_status_reg;
  logic [32:0] fix_result_ext;
  logic fix_carry_out, carry_in, irq;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0; // Cycles since start, for the hang limit
  // Invalid causes: x NaN, y NaN, opposite-signed add, like-signed sub, conversion
  logic [13:0] inv [5] = '{14'h0020, 14'h0400, 14'h0058, 14'h001C, 14'h0002};
  afs_op_e inv_k [5] = '{AFS_OP_ARITH, AFS_OP_ARITH, AFS_OP_ARITH, AFS_OP_ARITH,
    AFS_OP_TO_FIXED};

  afs_regfile_model u_src (.x_operand(opx), .y_operand(opy), .use_carry(misc[12]),
    .carry_in(carry_in), .fix_result_ext(fix_result_ext), .fix_carry_out(fix_carry_out));

  afs_flag_unit u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_float(op_float), .op_kind(op_kind), .op_subtract(misc[2]),
    .saturate_enable(misc[13]), .fix_result_ext(fix_result_ext),
    .fix_carry_out(fix_carry_out), .fp_result_zero(misc[8]), .fp_result_negative(misc[7]),
    .fp_tiny(misc[9]), .fp_exponent(fp_exp), .x_negative(misc[6]), .y_negative(misc[11]),
    .x_nan(misc[5]), .y_nan(misc[10]), .x_inf(misc[4]), .y_inf(misc[3]),
    .fix_conv_overflow(misc[1]), .cmp_x_gt_y(misc[0]), .carry_in(carry_in),
    .result_out(result_out), .arith_status_reg(arith_status_reg),
    .sticky_status_reg(sticky_status_reg), .irq(irq));

  // Free-running 250 MHz clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // Hang limit: the sequence needs little more than a hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  // Compare and count; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; data is looked at only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // One operation; ca other than FF adds a same-cycle register write
  task automatic op(input logic fl, input afs_op_e k, input logic [31:0] a,
    input logic [31:0] b, input logic [13:0] m = 14'h0, input logic [9:0] e = 10'h000,
    input logic [7:0] ca = 8'hFF, input logic [31:0] cd = 32'h0);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_float <= fl;
    op_kind <= k;
    opx <= a;
    opy <= b;
    misc <= m;
    fp_exp <= e;
    if (ca != 8'hFF) begin
      reg_wr <= 1'b1;
      reg_addr <= ca;
      reg_wdata <= cd;
    end
    @(posedge sys_clk);
    op_valid <= 1'b0;
    reg_wr <= 1'b0;
    #1;
  endtask

  // Counts, verdict, end of run
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(AFS_OFS_ARITH_STATUS_REG, 32'h0);
    rd(AFS_OFS_STICKY_STATUS_REG, 32'h0);
    wr(AFS_OFS_IRQ_EN, 32'h0000000F);
    // Fixed overflow wraps, then saturates; flag shows the raw result
    op(1'b0, AFS_OP_ARITH, 32'h7FFFFFFF, 32'h1);
    chk(arith_status_reg, 32'h6);
    chk(result_out, 32'h80000000);
    chk(sticky_status_reg, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rd(AFS_OFS_IRQ_STAT, 32'h4);
    op(1'b0, AFS_OP_ARITH, 32'h7FFFFFFF, 32'h1, 14'h2000);
    chk(arith_status_reg, 32'h2);
    chk(result_out, 32'h7FFFFFFF);
    // Zero result; sticky bit stays until software clears it
    op(1'b0, AFS_OP_LOGIC, 32'h0, 32'h0);
    chk(arith_status_reg, 32'h1);
    chk(sticky_status_reg, 32'h4);
    wr(AFS_OFS_IRQ_CLR, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(AFS_OFS_STICKY_STATUS_REG, 32'h0);
    chk(sticky_status_reg, 32'h0);
    // Halving add never flags overflow, yet still reports its carry
    op(1'b0, AFS_OP_AVERAGE, 32'h7FFFFFFF, 32'h1);
    chk(arith_status_reg, 32'h4);
    chk(sticky_status_reg, 32'h0);
    op(1'b0, AFS_OP_AVERAGE, 32'hFFFFFFFF, 32'h1);
    chk(arith_status_reg, 32'h9);
    // Carry out, then a carry form consuming it
    op(1'b0, AFS_OP_ARITH, 32'hFFFFFFFF, 32'h1);
    chk(arith_status_reg, 32'h9);
    chk({31'h0, carry_in}, 32'h1);
    op(1'b0, AFS_OP_ARITH, 32'h0, 32'h0, 14'h1000);
    chk(result_out, 32'h1);
    chk(arith_status_reg, 32'h0);
    // Sign flag only for magnitude and extract
    op(1'b0, AFS_OP_MAGNITUDE, 32'h5, 32'h0, 14'h0040);
    chk(arith_status_reg, 32'h10);
    op(1'b1, AFS_OP_SIGEXT, 32'h5, 32'h0, 14'h0040);
    chk(arith_status_reg, 32'h410);
    op(1'b0, AFS_OP_ARITH, 32'h5, 32'h0, 14'h0040);
    chk(arith_status_reg, 32'h0);
    // Every invalid cause except infinity into conversion, then conversion with saturation on
    foreach (inv[i]) begin
      op(1'b1, inv_k[i], 32'h1, 32'h0, inv[i]);
      chk(arith_status_reg, 32'h420);
    end
    op(1'b1, AFS_OP_TO_FIXED, 32'h1, 32'h0, 14'h2002);
    chk(arith_status_reg, 32'h400);
    rd(AFS_OFS_IRQ_STAT, 32'h8);
    wr(AFS_OFS_IRQ_CLR, 32'h8);
    // Exponent boundary and underflow
    op(1'b1, AFS_OP_ARITH, 32'h1, 32'h0, 14'h0, 10'h080);
    chk(arith_status_reg, 32'h402);
    op(1'b1, AFS_OP_ARITH, 32'h1, 32'h0, 14'h0, 10'h07F);
    chk(arith_status_reg, 32'h400);
    op(1'b1, AFS_OP_AVERAGE, 32'h1, 32'h0, 14'h0, 10'h080);
    chk(arith_status_reg, 32'h400);
    op(1'b1, AFS_OP_ARITH, 32'h1, 32'h0, 14'h0200);
    chk(arith_status_reg, 32'h401);
    chk(sticky_status_reg, 32'h23);
    rd(AFS_OFS_STICKY_STATUS_REG, 32'h23);
    // Compare history: greater, not greater, greater
    for (int i = 0; i < 3; i++) begin
      op(1'b0, AFS_OP_COMPARE, 32'h1, 32'h0, {13'h0, ~i[0]});
    end
    chk(arith_status_reg, 32'hA0000000);
    rd(AFS_OFS_ARITH_STATUS_REG, 32'hA0000000);
    // Software writes beat the same-cycle operation
    op(1'b0, AFS_OP_ARITH, 32'h7FFFFFFF, 32'h1, 14'h0, 10'h000, AFS_OFS_ARITH_STATUS_REG, 32'hFFFFFFFF);
    chk(arith_status_reg, 32'hFF00043F);
    chk(sticky_status_reg, 32'h27);
    wr(AFS_OFS_STICKY_STATUS_REG, 32'h0);
    op(1'b0, AFS_OP_ARITH, 32'h7FFFFFFF, 32'h1, 14'h0, 10'h000, AFS_OFS_STICKY_STATUS_REG, 32'h0);
    chk(sticky_status_reg, 32'h0);
    chk(arith_status_reg, 32'hFF000006);
    // Refused accesses and interrupt masking
    rd(8'h14, 32'h0);
    rd(AFS_OFS_IRQ_CLR, 32'h0);
    wr(AFS_OFS_IRQ_STAT, 32'h0);
    rd(AFS_OFS_IRQ_STAT, 32'h7);
    wr(AFS_OFS_IRQ_EN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(AFS_OFS_IRQ_EN, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(AFS_OFS_IRQ_EN, 32'h1);
    wr(AFS_OFS_IRQ_CLR, 32'h7);
    rd(AFS_OFS_IRQ_STAT, 32'h0);
    finish_test();
  end
endmodule
